/* oqcfg_regs.sv */
// o-qpsk baseband configuration and transmit header register bank
// Notes on behaviour
// R1 - direct modulation needs both bits, chip rate 0/1
// R2 - shaping bit: 0 raised cosine, 1 root raised
// R3 - chip rate codes 100/200/1000/2000 kchip/s, reset 100
// R4 - bit 7 multi-rate override enable, resets on
// R5 - bit 6 legacy override enable, resets on
// R6 - bits 5:3 legacy preamble threshold
// R7 - bits 2:0 multi-rate preamble threshold
// R8 - host sets spurious compensation near spur channels
// R9 - low power listen only when listen mode 0
// R10 - proprietary rate acceptance bit, resets to one
// R11 - legacy check type: 0 32-bit, 1 16-bit
// R12 - listen mode: mr, legacy, both, none
// R13 - high-rate legacy affects transmit and receive
// R14 - sfd search space selection, four codes
// R15 - frame format type one or two
// R16 - spare bit0 copied into transmitted header
// R17 - rate mode 0..3, 4 proprietary sets spare1
// R18 - bit 0 picks phy type for transmit
// R19 - receive status held until next frame start
// R20 - received check type by phy type
// R21 - override restarts detection on signal jump
// R22 - unassigned bits read zero, ignore writes
`timescale 1ns/10ps
module oqcfg_regs
    import oqcfg_pkg::*;
(
    input  wire logic         clk,                    // 25 mhz baseband clock
    input  wire logic         nrst,                   // synchronous reset, active low
    input  wire logic         reg_wr,                 // register write strobe
    input  wire logic         reg_rd,                 // register read strobe
    input  wire logic [7:0]   reg_addr,               // register index
    input  wire logic [7:0]   reg_wdata,              // write data
    output logic      [7:0]   reg_rdata,              // read data, registered
    input  wire logic         tx_frontend_direct_mod, // frontend direct modulation bit
    input  wire logic         general_check_type,     // general phy control check type
    input  wire logic         rx_frame_start,         // valid frame start pulse
    input  oqcfg_rxhdr_t      rx_hdr_in,              // header decoded by receiver
    input  wire logic         preamble_found,         // receiver has a preamble
    input  wire logic         power_jump_mr,          // strength rose over 12 db
    input  wire logic         power_jump_legacy,      // strength rose over 9 db
    output oqcfg_rx_t         rx_cfg,                 // decoded receive controls
    output oqcfg_tx_t         tx_cfg,                 // decoded transmit controls
    output logic              rx_check_type,          // check type of received frame
    output logic              rx_restart              // return to preamble search
);

    // register map, one byte per index
    //   index 00  chip rate, shaping and direct modulation
    //     bit 4   direct modulation request
    //     bit 3   shaping filter choice
    //     bit 1:0 chip rate code
    //   index 01  receiver override and detector thresholds
    //     bit 7   multi-rate override enable
    //     bit 6   legacy override enable
    //     bit 5:3 legacy detector threshold
    //     bit 2:0 multi-rate detector threshold
    //   index 02  receive mode and related switches
    //     bit 5   spurious compensation
    //     bit 4   reduced power listen
    //     bit 3   proprietary rate acceptance
    //     bit 2   legacy check type
    //     bit 1:0 listen mode
    //   index 03  legacy high rate and sfd search space
    //     bit 5   legacy high rate
    //     bit 3:2 sfd search space
    //   index 04  header of the next transmitted frame
    //     bit 5   frame format type
    //     bit 4   spare header bit 0
    //     bit 3:1 rate mode
    //     bit 0   phy type
    //   index 05  header of the last received frame, read only
    //     same layout as index 04
    //   any other index reads zero and drops writes
    //
    // timing seen from the host
    //   a write lands in its byte at the edge that takes it
    //   decoded outputs follow one edge later
    //   read data is valid one edge after the read strobe
    //   read data holds until the next read strobe
    //   a write and a read of one byte in the same cycle
    //   return the old value, since the mux sees the old byte
    //
    // limitations
    //   mode 4 at a slow chip rate is only flagged, not blocked;
    //   the transmitter decides what to do with such a header
    //   all inputs share the baseband clock, so none is synchronised
    //   a frame start held for two cycles captures twice, which is
    //   harmless while the receiver keeps its header steady

    // stored register bytes
    logic [7:0]   c0, c1, c2, c3, phrt;
    logic [7:0]   next_c0, next_c1, next_c2, next_c3, next_phrt;
    logic [7:0]   next_rdata;
    oqcfg_rxhdr_t rx_hdr, next_rx_hdr;                // captured receive status
    oqcfg_rx_t    next_rx_cfg;
    oqcfg_tx_t    next_tx_cfg;
    logic         next_rx_check_type;
    logic         next_rx_restart;

    // register write path; masks keep unassigned bits at zero
    // masking on the way in, not on the way out, keeps the stored
    // byte and the read value identical, so the read mux stays plain
    // the status byte has no write case, a write to it is dropped
    always_comb begin
        next_c0   = c0;
        next_c1   = c1;
        next_c2   = c2;
        next_c3   = c3;
        next_phrt = phrt;
        if (reg_wr) begin
            case (reg_addr)
                OQCFG_ADDR_C0:   next_c0   = reg_wdata & OQCFG_MASK_C0;   // [R22]
                OQCFG_ADDR_C1:   next_c1   = reg_wdata & OQCFG_MASK_C1;
                OQCFG_ADDR_C2:   next_c2   = reg_wdata & OQCFG_MASK_C2;   // [R22]
                OQCFG_ADDR_C3:   next_c3   = reg_wdata & OQCFG_MASK_C3;   // [R22]
                OQCFG_ADDR_PHRT: next_phrt = reg_wdata & OQCFG_MASK_PHRT; // [R22]
                default: begin
                    // unmapped index, write dropped
                end
            endcase
        end
    end

    // receive status capture, held between frame starts
    always_comb begin
        next_rx_hdr = rx_hdr;
        if (rx_frame_start) begin
            next_rx_hdr = rx_hdr_in; // [R19]
        end
    end

    // read mux; registered so the read data is a flop output
    // without a read strobe the flop keeps its value, so a slow
    // host may sample the byte at any time before its next read
    always_comb begin
        next_rdata = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                OQCFG_ADDR_C0:   next_rdata = c0;
                OQCFG_ADDR_C1:   next_rdata = c1;
                OQCFG_ADDR_C2:   next_rdata = c2;
                OQCFG_ADDR_C3:   next_rdata = c3;
                OQCFG_ADDR_PHRT: next_rdata = phrt;
                OQCFG_ADDR_PHRR: next_rdata = {2'h0, rx_hdr.frame_format_type,
                                               rx_hdr.header_spare_bit0, rx_hdr.rate_mode,
                                               rx_hdr.phy_type_select};
                default:         next_rdata = 8'h00; // unmapped reads zero
            endcase
        end
    end

    // decode receive controls
    always_comb begin
        next_rx_cfg.mr_override_enable        = c1[OQCFG_RXO_BIT];     // [R4]
        next_rx_cfg.legacy_override_enable    = c1[OQCFG_LEGACY_OVERRIDE_ENABLE_BIT];  // [R5]
        next_rx_cfg.legacy_preamble_threshold = c1[5:3];               // [R6]
        next_rx_cfg.mr_preamble_threshold     = c1[2:0];               // [R7]
        // active while set; channel choice is the host's job
        next_rx_cfg.spurious_comp_enable      = c2[OQCFG_SPC_BIT];     // [R8]
        // power saving only makes sense when legacy is not listened for
        next_rx_cfg.low_power_listen          = c2[OQCFG_RPC_BIT]
                                                && (c2[1:0] == OQCFG_RXM_MR); // [R9]
        next_rx_cfg.proprietary_rate_accept   = c2[OQCFG_PROP_BIT];    // [R10]
        next_rx_cfg.legacy_check_type         = c2[OQCFG_FCSL_BIT];    // [R11]
        // code 3 leaves both listeners off
        next_rx_cfg.listen_mr     = (c2[1:0] == OQCFG_RXM_MR)
                                    || (c2[1:0] == OQCFG_RXM_BOTH);    // [R12]
        next_rx_cfg.listen_legacy = (c2[1:0] == OQCFG_RXM_LEG)
                                    || (c2[1:0] == OQCFG_RXM_BOTH);    // [R12]
        next_rx_cfg.legacy_high_rate  = c3[OQCFG_HRL_BIT];             // [R13]
        next_rx_cfg.sfd_search_select = c3[3:2];                       // [R14]
    end

    // decode transmit controls
    always_comb begin
        // direct modulation ignored at the two fast chip rates
        next_tx_cfg.direct_mod_active = c0[OQCFG_DM_BIT] && tx_frontend_direct_mod
                                        && ((c0[1:0] == OQCFG_CHIP_100)
                                            || (c0[1:0] == OQCFG_CHIP_200)); // [R1]
        next_tx_cfg.root_raised_cosine_shape = c0[OQCFG_SHAPE_BIT];    // [R2]
        next_tx_cfg.chip_rate_select  = c0[1:0];                       // [R3]
        next_tx_cfg.frame_format_type = phrt[OQCFG_PPDU_BIT];          // [R15]
        next_tx_cfg.header_spare_bit0 = phrt[OQCFG_RB0_BIT];           // [R16]
        next_tx_cfg.rate_mode         = phrt[3:1];                     // [R17]
        next_tx_cfg.header_spare_bit1 = (phrt[3:1] == OQCFG_RATE_PROP); // [R17]
        // mode 4 only legal at the top chip rate; flagged rather than remapped
        next_tx_cfg.rate_mode_valid   = (phrt[3:1] <= OQCFG_RATE_STD_MAX)
                                        || ((phrt[3:1] == OQCFG_RATE_PROP)
                                            && (c0[1:0] == OQCFG_CHIP_2000)); // [R17]
        next_tx_cfg.phy_type_select   = phrt[OQCFG_LEG_BIT];           // [R18]
        next_tx_cfg.legacy_high_rate  = c3[OQCFG_HRL_BIT];             // [R13]
    end

    // received check type and override restart
    // the check type follows the captured header, not the live one,
    // so it stays put for the whole frame even if a new header
    // arrives on rx_hdr_in before the frame has been checked
    // restart needs a found preamble; a jump alone while searching
    // would only restart a search that is already running
    always_comb begin
        next_rx_check_type = rx_hdr.phy_type_select ? c2[OQCFG_FCSL_BIT]
                                                    : general_check_type; // [R20]
        next_rx_restart    = preamble_found
                             && ((c1[OQCFG_RXO_BIT] && power_jump_mr)
                                 || (c1[OQCFG_LEGACY_OVERRIDE_ENABLE_BIT] && power_jump_legacy)); // [R21]
    end

    // reset notes
    //   every flop below has a synchronous reset, so nrst must be
    //   low across at least one rising edge to take effect
    //   the configuration bytes reset to the power-up defaults
    //   decoded outputs reset to zero and pick up the defaults one
    //   edge after release; a consumer that looks in that single
    //   cycle sees overrides off, which is why the receiver is
    //   expected to stay idle until reset has been gone a while

    // configuration bytes; reset values give the power-up defaults
    always_ff @(posedge clk) begin
        if (!nrst) begin
            c0   <= OQCFG_RST_C0;   // [R3]
            c1   <= OQCFG_RST_C1;   // [R4] [R5]
            c2   <= OQCFG_RST_C2;   // [R10] [R11]
            c3   <= OQCFG_RST_C3;
            phrt <= OQCFG_RST_PHRT;
        end else begin
            c0   <= next_c0;
            c1   <= next_c1;
            c2   <= next_c2;
            c3   <= next_c3;
            phrt <= next_phrt;
        end
    end

    // captured receive status; clears to zero like the status byte
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_hdr <= '0;
        end else begin
            rx_hdr <= next_rx_hdr; // [R19]
        end
    end

    // read data flop; holding it spares the host a timing race
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // decoded receive controls
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_cfg <= '0;
        end else begin
            rx_cfg <= next_rx_cfg;
        end
    end

    // decoded transmit controls
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_cfg <= '0;
        end else begin
            tx_cfg <= next_tx_cfg;
        end
    end

    // received check type and override restart
    // restart is a level, it stays up while its conditions stand
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_check_type <= 1'b0;
            rx_restart    <= 1'b0;
        end else begin
            rx_check_type <= next_rx_check_type; // [R20]
            rx_restart    <= next_rx_restart;    // [R21]
        end
    end

endmodule

/* oqcfg_pkg.sv */
// package with register layout, reset values and decoded carrier types for the o-qpsk config bank
package oqcfg_pkg;
    // register indices; offsets are local choices within the baseband page
    localparam logic [7:0] OQCFG_ADDR_C0   = 8'h00;
    localparam logic [7:0] OQCFG_ADDR_C1   = 8'h01;
    localparam logic [7:0] OQCFG_ADDR_C2   = 8'h02;
    localparam logic [7:0] OQCFG_ADDR_C3   = 8'h03;
    localparam logic [7:0] OQCFG_ADDR_PHRT = 8'h04;
    localparam logic [7:0] OQCFG_ADDR_PHRR = 8'h05;
    // writable bit masks; unassigned bits stay zero
    localparam logic [7:0] OQCFG_MASK_C0   = 8'h1B;
    localparam logic [7:0] OQCFG_MASK_C1   = 8'hFF;
    localparam logic [7:0] OQCFG_MASK_C2   = 8'h3F;
    localparam logic [7:0] OQCFG_MASK_C3   = 8'h2C;
    localparam logic [7:0] OQCFG_MASK_PHRT = 8'h3F;
    // reset values
    localparam logic [7:0] OQCFG_RST_C0    = 8'h00;
    localparam logic [7:0] OQCFG_RST_C1    = 8'hDB;
    localparam logic [7:0] OQCFG_RST_C2    = 8'h0C;
    localparam logic [7:0] OQCFG_RST_C3    = 8'h00;
    localparam logic [7:0] OQCFG_RST_PHRT  = 8'h00;
    // field positions
    localparam int OQCFG_DM_BIT     = 4;
    localparam int OQCFG_SHAPE_BIT  = 3;
    localparam int OQCFG_RXO_BIT    = 7;
    localparam int OQCFG_LEGACY_OVERRIDE_ENABLE_BIT = 6;
    localparam int OQCFG_SPC_BIT    = 5;
    localparam int OQCFG_RPC_BIT    = 4;
    localparam int OQCFG_PROP_BIT   = 3;
    localparam int OQCFG_FCSL_BIT   = 2;
    localparam int OQCFG_HRL_BIT    = 5;
    localparam int OQCFG_PPDU_BIT   = 5;
    localparam int OQCFG_RB0_BIT    = 4;
    localparam int OQCFG_LEG_BIT    = 0;
    // field codes
    localparam logic [1:0] OQCFG_CHIP_100  = 2'h0;
    localparam logic [1:0] OQCFG_CHIP_200  = 2'h1;
    localparam logic [1:0] OQCFG_CHIP_2000 = 2'h3;
    localparam logic [1:0] OQCFG_RXM_MR    = 2'h0;
    localparam logic [1:0] OQCFG_RXM_LEG   = 2'h1;
    localparam logic [1:0] OQCFG_RXM_BOTH  = 2'h2;
    localparam logic [2:0] OQCFG_RATE_STD_MAX = 3'h3;
    localparam logic [2:0] OQCFG_RATE_PROP    = 3'h4;

    // decoded receive controls
    typedef struct packed {
        logic       mr_override_enable;
        logic       legacy_override_enable;
        logic [2:0] mr_preamble_threshold;
        logic [2:0] legacy_preamble_threshold;
        logic       spurious_comp_enable;
        logic       low_power_listen;
        logic       proprietary_rate_accept;
        logic       legacy_check_type;
        logic       listen_mr;
        logic       listen_legacy;
        logic       legacy_high_rate;
        logic [1:0] sfd_search_select;
    } oqcfg_rx_t;

    // decoded transmit controls
    typedef struct packed {
        logic       direct_mod_active;
        logic       root_raised_cosine_shape;
        logic [1:0] chip_rate_select;
        logic       frame_format_type;
        logic       header_spare_bit0;
        logic       header_spare_bit1;
        logic [2:0] rate_mode;
        logic       rate_mode_valid;
        logic       phy_type_select;
        logic       legacy_high_rate;
    } oqcfg_tx_t;

    // received header status captured at frame start
    typedef struct packed {
        logic       frame_format_type;
        logic       header_spare_bit0;
        logic [2:0] rate_mode;
        logic       phy_type_select;
    } oqcfg_rxhdr_t;
endpackage

/* oqcfg_regs_properties.sv */
// checker of the o-qpsk configuration bank port behaviour
`timescale 1ns/10ps
module oqcfg_regs_checker
    import oqcfg_pkg::*;
(
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic       tx_frontend_direct_mod,
    input wire logic       general_check_type,
    input wire logic       rx_frame_start,
    input oqcfg_rxhdr_t    rx_hdr_in,
    input wire logic       preamble_found,
    input wire logic       power_jump_mr,
    input wire logic       power_jump_legacy,
    input oqcfg_rx_t       rx_cfg,
    input oqcfg_tx_t       tx_cfg,
    input wire logic       rx_check_type,
    input wire logic       rx_restart
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // a multi-rate frame start followed by quiet cycles
    sequence s_mr_frame;
        rx_frame_start && !rx_hdr_in.phy_type_select;
    endsequence
    sequence s_quiet;
        !rx_frame_start && $stable(general_check_type);
    endsequence
    AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    AST_UNMAPPED_READ: assert property (
        reg_rd && reg_addr > OQCFG_ADDR_PHRR |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_C0_SPARE_BITS: assert property (
        reg_rd && reg_addr == OQCFG_ADDR_C0 |=> (reg_rdata & 8'hE4) == 8'h00)
        else $error("unassigned bits of byte 0 set");
    AST_DM_GATE: assert property (tx_cfg.direct_mod_active |->
        !tx_cfg.chip_rate_select[1] && $past(tx_frontend_direct_mod))
        else $error("direct modulation without its conditions");
    AST_LPL_GATE: assert property (rx_cfg.low_power_listen |->
        rx_cfg.listen_mr && !rx_cfg.listen_legacy)
        else $error("low power listen outside listen mode 0");
    AST_MODE4: assert property (tx_cfg.rate_mode == OQCFG_RATE_PROP |->
        tx_cfg.header_spare_bit1 && tx_cfg.rate_mode_valid == (tx_cfg.chip_rate_select == 2'h3))
        else $error("mode 4 spare bit or validity wrong");
    AST_RESTART: assert property ($past(nrst) |-> rx_restart == ($past(preamble_found) &&
        (rx_cfg.mr_override_enable && $past(power_jump_mr) ||
         rx_cfg.legacy_override_enable && $past(power_jump_legacy))))
        else $error("restart does not follow override conditions");
    AST_CHECK_MR: assert property (s_mr_frame ##1 s_quiet [*3] |->
        rx_check_type == general_check_type)
        else $error("multi-rate check type not from general setting");
endmodule
bind oqcfg_regs oqcfg_regs_checker i_chk (.clk, .nrst, .reg_rd, .reg_addr, .reg_rdata,
    .tx_frontend_direct_mod, .general_check_type, .rx_frame_start, .rx_hdr_in,
    .preamble_found, .power_jump_mr, .power_jump_legacy, .rx_cfg, .tx_cfg,
    .rx_check_type, .rx_restart);

/* oqcfg_host_model.sv */
// host model issuing single byte register accesses
`timescale 1ns/10ps
module oqcfg_host_model (
    input  wire logic       clk,       // baseband clock
    input  wire logic [7:0] reg_rdata, // read data from the bank
    output logic            reg_wr,    // write strobe
    output logic            reg_rd,    // read strobe
    output logic      [7:0] reg_addr,  // register index
    output logic      [7:0] reg_wdata  // write data
);
    // idle lines parked away from any mapped index
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'hFF;
        reg_wdata = 8'h00;
    end
    // launch after a falling edge, taken at the rising edge, released with
    // flipped lines so stale values never pass for fresh ones
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge clk);
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        q = reg_rdata;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule

/* tb_oqcfg_regs.sv */
// self-checking bench for the o-qpsk configuration bank
`timescale 1ns/10ps
module tb_oqcfg_regs;
    import oqcfg_pkg::*;
    logic         clk, nrst, reg_wr, reg_rd, rx_check_type, rx_restart;
    logic         tx_frontend_direct_mod, general_check_type, rx_frame_start;
    logic         preamble_found, power_jump_mr, power_jump_legacy;
    logic   [7:0] reg_addr, reg_wdata, reg_rdata, q;
    oqcfg_rxhdr_t rx_hdr_in;
    oqcfg_rx_t    rx_cfg;
    oqcfg_tx_t    tx_cfg;
    int           num_errors = 0;
    int           checked = 0;
    int           cycles = 0;
    oqcfg_regs i_dut (.clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .tx_frontend_direct_mod, .general_check_type, .rx_frame_start, .rx_hdr_in,
        .preamble_found, .power_jump_mr, .power_jump_legacy, .rx_cfg, .tx_cfg,
        .rx_check_type, .rx_restart);
    oqcfg_host_model i_host (.clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // a hang is cut off far beyond the roughly 140 cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // decoded outputs land one edge after the register
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.access(1'b1, a, d, q);
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_host.access(1'b0, a, 8'h00, q);
        chk("rdata", q, e);
    endtask
    task automatic t_mask;
        logic [7:0] m [8] = '{8'h1B, 8'hFF, 8'h3F, 8'h2C, 8'h3F, 8'h00, 8'h00, 8'h00};
        rd(OQCFG_ADDR_C2, 8'h0C);
        rd(OQCFG_ADDR_C1, 8'hDB);
        chk("ovr0", {6'h0, rx_cfg.mr_override_enable, rx_cfg.legacy_override_enable}, 8'h03);
        chk("chip0", 8'(tx_cfg.chip_rate_select), 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(8'(i), 8'hFF);
            rd(8'(i), m[i]);
        end
    endtask
    task automatic t_c0;
        for (int i = 0; i < 8; i++) begin
            tx_frontend_direct_mod = i[2];
            wr(OQCFG_ADDR_C0, 8'h10 | 8'(i[1:0]) | {4'h0, i[0], 3'h0});
            chk("dm", 8'(tx_cfg.direct_mod_active), 8'(i[2] && i[1:0] < 2));
            chk("chip", 8'(tx_cfg.chip_rate_select), 8'(i[1:0]));
            chk("rrc", 8'(tx_cfg.root_raised_cosine_shape), 8'(i[0]));
        end
    endtask
    task automatic t_rx;
        wr(OQCFG_ADDR_C1, 8'h2C);
        chk("thr", {2'h0, rx_cfg.legacy_preamble_threshold, rx_cfg.mr_preamble_threshold}, 8'h2C);
        chk("ovr", {6'h0, rx_cfg.mr_override_enable, rx_cfg.legacy_override_enable}, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(OQCFG_ADDR_C2, 8'h34 | 8'(m));
            chk("lsn", {6'h0, rx_cfg.listen_mr, rx_cfg.listen_legacy}, 8'({m == 0 || m == 2, m == 1 || m == 2}));
            chk("lpl", 8'(rx_cfg.low_power_listen), 8'(m == 0));
            chk("c2f", {5'h0, rx_cfg.spurious_comp_enable, rx_cfg.proprietary_rate_accept, rx_cfg.legacy_check_type}, 8'h05);
        end
        for (int n = 0; n < 4; n++) begin
            wr(OQCFG_ADDR_C3, {2'h0, n[0], 1'h0, 2'(n), 2'h0});
            chk("sfd", 8'(rx_cfg.sfd_search_select), 8'(n));
            chk("hrl", {6'h0, rx_cfg.legacy_high_rate, tx_cfg.legacy_high_rate}, {6'h0, n[0], n[0]});
        end
    endtask
    task automatic t_tx;
        wr(OQCFG_ADDR_C0, 8'h03);
        for (int r = 0; r < 5; r++) begin
            wr(OQCFG_ADDR_PHRT, {2'h0, r[0], r[1], 3'(r), r[0]});
            chk("phr", {tx_cfg.frame_format_type, tx_cfg.header_spare_bit0, tx_cfg.rate_mode, tx_cfg.phy_type_select, tx_cfg.header_spare_bit1, tx_cfg.rate_mode_valid}, {r[0], r[1], 3'(r), r[0], r == 4, 1'b1});
        end
        wr(OQCFG_ADDR_C0, 8'h00);
        chk("m4", 8'({tx_cfg.header_spare_bit1, tx_cfg.rate_mode_valid}), 8'h02);
    endtask
    // capture a legacy then a multi-rate header; status holds between starts
    task automatic frame(input logic [5:0] h);
        rx_hdr_in = h;
        @(negedge clk) rx_frame_start = 1'b1;
        @(negedge clk) rx_frame_start = 1'b0;
        rx_hdr_in = ~h;
    endtask
    task automatic t_status;
        frame(6'h2B);
        rd(OQCFG_ADDR_PHRR, 8'h2B);
        chk("fcs", 8'(rx_check_type), 8'h01);
        wr(OQCFG_ADDR_C2, 8'h00);
        chk("fcs", 8'(rx_check_type), 8'h00);
        general_check_type = 1'b1;
        frame(6'h14);
        rd(OQCFG_ADDR_PHRR, 8'h14);
        chk("fcs", 8'(rx_check_type), 8'h01);
    endtask
    task automatic t_restart;
        {preamble_found, power_jump_mr, power_jump_legacy} = 3'h7;
        wr(OQCFG_ADDR_C1, 8'h00);
        chk("rst", 8'(rx_restart), 8'h00);
        wr(OQCFG_ADDR_C1, 8'h80);
        chk("rst", 8'(rx_restart), 8'h01);
        power_jump_mr = 1'b0;
        @(negedge clk);
        chk("rst", 8'(rx_restart), 8'h00);
        wr(OQCFG_ADDR_C1, 8'h40);
        chk("rst", 8'(rx_restart), 8'h01);
        preamble_found = 1'b0;
        @(negedge clk);
        chk("rst", 8'(rx_restart), 8'h00);
    endtask
    task automatic conclude;
        if (num_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        {tx_frontend_direct_mod, general_check_type, rx_frame_start} = 3'h0;
        {preamble_found, power_jump_mr, power_jump_legacy} = 3'h0;
        rx_hdr_in = 6'h00;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        t_mask();
        t_c0();
        t_rx();
        t_tx();
        t_status();
        t_restart();
        conclude();
    end
endmodule
